// File: hdl/aocsf_defs.svh
`ifndef AOCSF_DEFS_SVH
`define AOCSF_DEFS_SVH

// Register byte offsets on the AHB-Lite window.
`define AOCSF_ADDR_W 8
`define AOCSF_ADDR_CTRL 8'h00
`define AOCSF_ADDR_STEP 8'h04
`define AOCSF_ADDR_DIV 8'h08
`define AOCSF_ADDR_POS 8'h0c
`define AOCSF_ADDR_STAT 8'h10

// Control register bit positions.
`define AOCSF_CTRL_MASTER 0
`define AOCSF_CTRL_EDGE 1
`define AOCSF_CTRL_DRIVE 2
`define AOCSF_CTRL_PULSE 3
`define AOCSF_CTRL_ORDER 4
`define AOCSF_CTRL_TXON 5

// Divider register field positions.
`define AOCSF_DIV_BCK_LSB 0
`define AOCSF_DIV_FLEN_LSB 16

// Position register field positions.
`define AOCSF_POS_LEFT_LSB 0
`define AOCSF_POS_RIGHT_LSB 16
`define AOCSF_POS_STOP_LSB 28

// Status register field positions.
`define AOCSF_STAT_FS 0
`define AOCSF_STAT_BCK 1
`define AOCSF_STAT_PEND 2
`define AOCSF_STAT_MASTER 3
`define AOCSF_STAT_IDX_LSB 4
`define AOCSF_STAT_FCNT_LSB 16

// Synthesizer step multiplier, field limits, reset word and bus okay response.
`define AOCSF_DDS_MULT 32'h0000_0003
`define AOCSF_TOP_BIT 4'hf
`define AOCSF_WORD_BITS 5'h10
`define AOCSF_RESET_WORD 32'h0000_0000
`define AOCSF_AHB_OKAY 1'b0

`endif

// File: hdl/aocsf_pkg.sv
package aocsf_pkg;

   // One left and one right sample for a frame.
   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } aocsf_sample_s;

   // Software control of the framer and clocks.
   typedef struct packed {
      logic master;
      logic edge_rise;
      logic drive_rise;
      logic pulse;
      logic lsb_first;
      logic tx_on;
      logic [31:0] step;
      logic [7:0] bck_div;
      logic [8:0] flen_div;
      logic [8:0] left_start;
      logic [8:0] right_start;
      logic [3:0] stop_idx;
   } aocsf_ctrl_s;

   // Two-way pin as a drive level and an output enable.
   typedef struct packed {
      logic drive;
      logic en;
   } aocsf_pin_s;

endpackage : aocsf_pkg

// File: hdl/aocsf_dds.sv
`timescale 1ns/100ps
`include "aocsf_defs.svh"

module aocsf_dds (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Frequency step.
   input wire logic [31:0] step,
   // Square wave output.
   output logic osc
);

   logic [31:0] acc;
   wire [31:0] incr = 32'(step * `AOCSF_DDS_MULT);
   wire [31:0] next_acc = acc + incr;

   // The step only changes the phase increment, never the phase itself.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc <= `AOCSF_RESET_WORD;
         osc <= 1'b0;
      end else begin
         acc <= next_acc;
         osc <= next_acc[31];
      end
   end

endmodule : aocsf_dds

// File: hdl/aocsf_top.sv
// Summary of operation
// - Oversample clock frequency is three times step times clock over two^32.
// - A new step changes phase speed only, never the clock level at once.
// - Synthesizer output always drives the oversample clock pin.
// - Master select 0 makes bit clock and sync inputs, 1 makes them outputs.
// - As master, bit clock is oversample clock divided by divider plus one.
// - As master, each frame lasts frame length divider plus one bit clocks.
// - Bit clock pin signal is always the shift clock of the framer.
// - Frame sync pin signal always starts a new frame.
// - Bit clock at most 20 MHz, sample rate at most 100 kHz.
// - Slave bit clock is asynchronous and is synchronised before use.
// - Sync sampled on edge opposite to data; master changes sync with data.
// - Frame edge 0 starts frames on sync fall, 1 on sync rise.
// - Drive edge 0 samples sync on rise, data on fall; 1 swaps them.
// - Master sync is 50% duty when pulse select is 0, one bit when 1.
// - Two 9-bit start fields place the left and right samples, reset zero.
// - MSB first sends bit 15 down to the stop index.
// - LSB first sends stop index bit up to bit 15.
// - Stop index 0 to 15 suppresses sample bits below it.
// - Frame bits outside both sample fields are zero.
// - Each frame loads one left and one right sample on the shift edge that sends frame bit 0 from the previous pair.
// - Step, bit clock divider and frame length divider reset to zero.
`timescale 1ns/100ps
`include "aocsf_defs.svh"

module aocsf_top
   import aocsf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Sample source.
   input wire aocsf_sample_s sample_in,
   input wire logic sample_valid,
   output logic sample_ready,
   // Converter pins.
   output logic oversample_clock_out,
   input wire logic serial_bit_clock_pin,
   output aocsf_pin_s serial_bit_clock,
   input wire logic frame_sync_pin,
   output aocsf_pin_s frame_sync,
   output logic serial_data_out
);

   // Returns {hit, bit} for one channel at one frame bit index.
   function automatic logic [1:0] chan_bit(
      input logic [15:0] word,
      input logic [8:0] start,
      input logic [8:0] idx,
      input logic [3:0] stop,
      input logic lsb_first
   );
      logic [9:0] off;
      logic [4:0] len;
      logic hit;
      logic [3:0] sel;
      off = {1'b0, idx} - {1'b0, start};
      len = `AOCSF_WORD_BITS - {1'b0, stop};
      hit = (idx >= start) && (off < {5'h00, len});
      if (lsb_first) begin
         sel = stop + off[3:0];
      end else begin
         sel = `AOCSF_TOP_BIT - off[3:0];
      end
      chan_bit = {hit, hit & word[sel]};
   endfunction : chan_bit

   // Software registers.
   aocsf_ctrl_s ctrl;

   // Bus data phase.
   logic dp_write;
   logic [`AOCSF_ADDR_W-1:0] dp_addr;

   // Address phase decode.
   wire addr_take = hsel & hready & htrans[1];
   wire [`AOCSF_ADDR_W-1:0] a_addr = haddr[`AOCSF_ADDR_W-1:0];
   wire wr_ctrl = dp_write & (dp_addr == `AOCSF_ADDR_CTRL);
   wire wr_step = dp_write & (dp_addr == `AOCSF_ADDR_STEP);
   wire wr_div = dp_write & (dp_addr == `AOCSF_ADDR_DIV);
   wire wr_pos = dp_write & (dp_addr == `AOCSF_ADDR_POS);

   // Oversample clock.
   logic osc;

   // Master bit clock generator.
   logic osc_d;
   logic [7:0] bck_cnt;
   logic bck_gen;

   // Pin synchronisers.
   logic bck_s1;
   logic bck_s2;
   logic fs_s1;
   logic fs_s2;

   // Shift clock edge detect.
   logic bck_d;

   // Frame sync generator.
   logic [8:0] fs_cnt;
   logic fs_gen;

   // Framer state.
   logic fs_prev;
   logic start_pend;
   logic [8:0] bit_idx;
   logic sd;
   logic [15:0] frame_cnt;

   // Sample buffering.
   aocsf_sample_s pend;
   aocsf_sample_s shadow;
   logic pend_full;

   // Status word.
   logic [31:0] stat_word;
   logic [31:0] rd_mux;

   aocsf_dds u_dds (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .step(ctrl.step),
      .osc(osc)
   );

   assign oversample_clock_out = osc;

   // Register write, one cycle after the address phase.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else begin
         dp_write <= addr_take & hwrite;
         dp_addr <= a_addr;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl.master <= hwdata[`AOCSF_CTRL_MASTER];
            ctrl.edge_rise <= hwdata[`AOCSF_CTRL_EDGE];
            ctrl.drive_rise <= hwdata[`AOCSF_CTRL_DRIVE];
            ctrl.pulse <= hwdata[`AOCSF_CTRL_PULSE];
            ctrl.lsb_first <= hwdata[`AOCSF_CTRL_ORDER];
            ctrl.tx_on <= hwdata[`AOCSF_CTRL_TXON];
         end
         if (wr_step) begin
            ctrl.step <= hwdata;
         end
         if (wr_div) begin
            ctrl.bck_div <= hwdata[`AOCSF_DIV_BCK_LSB +: 8];
            ctrl.flen_div <= hwdata[`AOCSF_DIV_FLEN_LSB +: 9];
         end
         if (wr_pos) begin
            ctrl.left_start <= hwdata[`AOCSF_POS_LEFT_LSB +: 9];
            ctrl.right_start <= hwdata[`AOCSF_POS_RIGHT_LSB +: 9];
            ctrl.stop_idx <= hwdata[`AOCSF_POS_STOP_LSB +: 4];
         end
      end
   end

   // Read data, selected in the address phase and held in the data phase.
   always_comb begin
      stat_word = '0;
      stat_word[`AOCSF_STAT_FS] = fs_prev;
      stat_word[`AOCSF_STAT_BCK] = bck_d;
      stat_word[`AOCSF_STAT_PEND] = pend_full;
      stat_word[`AOCSF_STAT_MASTER] = ctrl.master;
      stat_word[`AOCSF_STAT_IDX_LSB +: 9] = bit_idx;
      stat_word[`AOCSF_STAT_FCNT_LSB +: 16] = frame_cnt;
   end

   always_comb begin
      rd_mux = '0;
      unique case (a_addr)
         `AOCSF_ADDR_CTRL: begin
            rd_mux[`AOCSF_CTRL_MASTER] = ctrl.master;
            rd_mux[`AOCSF_CTRL_EDGE] = ctrl.edge_rise;
            rd_mux[`AOCSF_CTRL_DRIVE] = ctrl.drive_rise;
            rd_mux[`AOCSF_CTRL_PULSE] = ctrl.pulse;
            rd_mux[`AOCSF_CTRL_ORDER] = ctrl.lsb_first;
            rd_mux[`AOCSF_CTRL_TXON] = ctrl.tx_on;
         end
         `AOCSF_ADDR_STEP: begin
            rd_mux = ctrl.step;
         end
         `AOCSF_ADDR_DIV: begin
            rd_mux[`AOCSF_DIV_BCK_LSB +: 8] = ctrl.bck_div;
            rd_mux[`AOCSF_DIV_FLEN_LSB +: 9] = ctrl.flen_div;
         end
         `AOCSF_ADDR_POS: begin
            rd_mux[`AOCSF_POS_LEFT_LSB +: 9] = ctrl.left_start;
            rd_mux[`AOCSF_POS_RIGHT_LSB +: 9] = ctrl.right_start;
            rd_mux[`AOCSF_POS_STOP_LSB +: 4] = ctrl.stop_idx;
         end
         `AOCSF_ADDR_STAT: begin
            rd_mux = stat_word;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= `AOCSF_RESET_WORD;
      end else if (addr_take & ~hwrite) begin
         hrdata <= rd_mux;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = `AOCSF_AHB_OKAY;

   // Master bit clock: toggles every divider plus one oversample edges.
   wire osc_edge = osc ^ osc_d;
   wire bck_wrap = (bck_cnt >= ctrl.bck_div);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         osc_d <= 1'b0;
         bck_cnt <= '0;
         bck_gen <= 1'b0;
      end else begin
         osc_d <= osc;
         if (osc_edge) begin
            bck_cnt <= bck_wrap ? 8'h00 : bck_cnt + 8'h01;
            if (bck_wrap) begin
               bck_gen <= ~bck_gen;
            end
         end
      end
   end

   // Two flip-flops on every pin input before any logic reads it.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bck_s1 <= 1'b0;
         bck_s2 <= 1'b0;
         fs_s1 <= 1'b0;
         fs_s2 <= 1'b0;
      end else begin
         bck_s1 <= serial_bit_clock_pin;
         bck_s2 <= bck_s1;
         fs_s1 <= frame_sync_pin;
         fs_s2 <= fs_s1;
      end
   end

   // Pin directions follow the master select.
   assign serial_bit_clock.en = ctrl.master;
   assign serial_bit_clock.drive = bck_gen;
   assign frame_sync.en = ctrl.master;
   assign frame_sync.drive = fs_gen;

   // The pin level, driven by either party, is the shift clock and sync.
   wire bck_lvl = ctrl.master ? bck_gen : bck_s2;
   wire fs_lvl = ctrl.master ? fs_gen : fs_s2;
   wire bck_rise = bck_lvl & ~bck_d;
   wire bck_fall = ~bck_lvl & bck_d;
   wire samp_ev = ctrl.drive_rise ? bck_fall : bck_rise;
   wire shift_ev = ctrl.drive_rise ? bck_rise : bck_fall;

   // Master frame sync, changed on the data edge.
   wire fs_last = (fs_cnt >= ctrl.flen_div);
   wire [8:0] next_fs_cnt = fs_last ? 9'h000 : fs_cnt + 9'h001;
   wire [9:0] fs_half = ({1'b0, ctrl.flen_div} + 10'h001) >> 1;
   wire fs_first = ctrl.pulse ? (next_fs_cnt == 9'h000)
                              : ({1'b0, next_fs_cnt} < fs_half);
   wire next_fs_gen = ctrl.edge_rise ? fs_first : ~fs_first;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bck_d <= 1'b0;
         fs_cnt <= '0;
         fs_gen <= 1'b0;
      end else begin
         bck_d <= bck_lvl;
         if (ctrl.master & shift_ev) begin
            fs_cnt <= next_fs_cnt;
            fs_gen <= next_fs_gen;
         end
      end
   end

   // Frame start detection on the sampling edge.
   wire fs_start = ctrl.edge_rise ? (~fs_prev & fs_lvl)
                                  : (fs_prev & ~fs_lvl);

   // Frame bit index and sample bits.
   wire [8:0] next_idx = start_pend ? 9'h000 : bit_idx + 9'h001;
   wire [1:0] left_hit = chan_bit(shadow.left, ctrl.left_start, next_idx,
                                  ctrl.stop_idx, ctrl.lsb_first);
   wire [1:0] right_hit = chan_bit(shadow.right, ctrl.right_start, next_idx,
                                   ctrl.stop_idx, ctrl.lsb_first);
   wire next_sd = left_hit[1] ? left_hit[0] : (right_hit[1] & right_hit[0]);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fs_prev <= 1'b0;
         start_pend <= 1'b0;
         bit_idx <= '0;
         sd <= 1'b0;
         frame_cnt <= '0;
      end else begin
         if (samp_ev) begin
            fs_prev <= fs_lvl;
         end
         if (samp_ev & fs_start) begin
            start_pend <= 1'b1;
         end else if (shift_ev) begin
            start_pend <= 1'b0;
         end
         if (shift_ev | ~ctrl.tx_on) begin
            sd <= ctrl.tx_on & next_sd;
         end
         if (shift_ev) begin
            bit_idx <= next_idx;
            if (start_pend) begin
               frame_cnt <= frame_cnt + 16'h0001;
            end
         end
      end
   end

   assign serial_data_out = sd;
   // Sample pair buffering between the source and the framer.
   wire frame_load = shift_ev & start_pend;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pend <= '0;
         shadow <= '0;
         pend_full <= 1'b0;
      end else begin
         if (frame_load) begin
            shadow <= pend;
         end
         if (sample_valid & sample_ready) begin
            pend <= sample_in;
            pend_full <= 1'b1;
         end else if (frame_load) begin
            pend_full <= 1'b0;
         end
      end
   end

   assign sample_ready = ~pend_full;

endmodule : aocsf_top

// File: verif/aocsf_properties.sv
`timescale 1ns/100ps
`include "aocsf_defs.svh"

module aocsf_props
   import aocsf_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Register bus.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Source and pins.
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic oversample_clock_out,
   input wire aocsf_pin_s serial_bit_clock,
   input wire aocsf_pin_s frame_sync,
   input wire logic serial_data_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic wr_q;
   logic [7:0] wa_q;
   logic [5:0] ctrl;
   logic [7:0] bdiv;
   logic [7:0] quiet;
   logic osc_d;
   logic osc_dd;
   wire take = hsel && hready && htrans[1];
   wire put = wr_q && (wa_q == `AOCSF_ADDR_CTRL || wa_q == `AOCSF_ADDR_DIV);
   // Shadow of the control and divider writes, and cycles since the last one.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         ctrl <= 6'h00;
         bdiv <= 8'h00;
         quiet <= 8'h00;
         osc_d <= 1'b0;
         osc_dd <= 1'b0;
      end else begin
         wr_q <= take && hwrite;
         wa_q <= haddr[7:0];
         osc_d <= oversample_clock_out;
         osc_dd <= osc_d;
         quiet <= put ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
         if (wr_q && wa_q == `AOCSF_ADDR_CTRL) ctrl <= hwdata[5:0];
         if (wr_q && wa_q == `AOCSF_ADDR_DIV) bdiv <= hwdata[7:0];
      end
   end
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   read_hold_a: assert property (!take |=> $stable(hrdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (take && !hwrite && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   pin_dir_a: assert property (quiet > 8'd2 |-> serial_bit_clock.en == ctrl[0] && frame_sync.en == ctrl[0])
      else $error("pin direction differs from master select");
   tx_quiet_a: assert property (quiet > 8'd2 && !ctrl[5] |-> !serial_data_out)
      else $error("data driven while transmission off");
   src_take_a: assert property (sample_valid && sample_ready |=> !sample_ready)
      else $error("source ready held after a pair was taken");
   bck_follow_a: assert property (quiet > 8'd3 && ctrl[0] && bdiv == 8'h00 |-> $changed(serial_bit_clock.drive) == (osc_d != osc_dd))
      else $error("bit clock not following oscillator");
   sync_edge_a: assert property (quiet == 8'hff && ctrl[0] && $changed(frame_sync.drive) |-> serial_bit_clock.drive == ctrl[2])
      else $error("sync changed away from data edge");
endmodule : aocsf_props

bind aocsf_top aocsf_props u_props (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
   .sample_ready(sample_ready), .oversample_clock_out(oversample_clock_out),
   .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync),
   .serial_data_out(serial_data_out));

// File: verif/aocsf_conv_model.sv
`timescale 1ns/100ps

module aocsf_conv_model
   import aocsf_pkg::*;
#(
   parameter int slave_len = 40
)
(
   // Design pins.
   input wire aocsf_pin_s bck_o,
   input wire aocsf_pin_s fs_o,
   input wire logic sd,
   output logic bck_pin,
   output logic fs_pin,
   // Framing setup.
   input wire logic edge_rise,
   input wire logic drive_rise,
   // Captured frame.
   output logic [63:0] last_frame,
   output logic [9:0] last_len,
   output logic [9:0] last_first,
   output logic [15:0] frames
);
   logic bck_m = 1'b0;
   logic fs_m = 1'b0;
   logic fs_q = 1'b0;
   logic [63:0] cur = '0;
   logic [9:0] idx = 10'h3ff;
   logic [8:0] cnt = '0;
   logic [9:0] lvl = '0;
   wire samp = bck_pin ^ drive_rise;
   wire start = (fs_q != fs_pin) && (fs_pin == edge_rise);
   assign bck_pin = bck_o.en ? bck_o.drive : bck_m;
   assign fs_pin = fs_o.en ? fs_o.drive : fs_m;
   initial begin
      last_frame = '0;
      last_len = '0;
      last_first = '0;
      frames = '0;
   end
   // Converter bit clock, free running and unrelated to the main clock.
   always #200 bck_m = ~bck_m;
   always @(posedge bck_m or negedge bck_m) begin
      if (bck_m == drive_rise) begin
         cnt = (cnt == slave_len - 1) ? 9'h000 : cnt + 9'h001;
         fs_m = (cnt < slave_len / 2) ? edge_rise : !edge_rise;
      end
   end
   // Capture on the edge opposite the data edge; a sync edge opens a frame.
   always @(posedge samp) begin
      if (idx < 10'd64) cur[idx[5:0]] = sd;
      if (idx != 10'h3ff) idx = idx + 10'd1;
      if (start) begin
         last_frame = cur;
         last_len = idx;
         last_first = lvl;
         frames = frames + 16'd1;
         cur = '0;
         idx = '0;
         lvl = '0;
      end
      if (fs_pin == edge_rise && lvl != 10'h3ff) lvl = lvl + 10'd1;
      fs_q = fs_pin;
   end
endmodule : aocsf_conv_model

// File: verif/test_audio_out_clock_and_serial_framer.sv
`timescale 1ns/100ps
`include "aocsf_defs.svh"

module test_audio_out_clock_and_serial_framer
   import aocsf_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rstn = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, sample_ready, osc, sd, bck_pin, fs_pin;
   aocsf_sample_s pair = '0;
   logic sample_valid = 1'b0;
   logic er = 1'b0;
   logic dr = 1'b0;
   aocsf_pin_s bck_o, fs_o;
   logic [63:0] last_frame;
   logic [9:0] last_len;
   logic [9:0] last_first;
   logic [15:0] frames;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   integer seed = 32'h298d;

   aocsf_top uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_in(pair),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .oversample_clock_out(osc),
      .serial_bit_clock_pin(bck_pin), .serial_bit_clock(bck_o), .frame_sync_pin(fs_pin),
      .frame_sync(fs_o), .serial_data_out(sd));
   aocsf_conv_model conv (.bck_o(bck_o), .fs_o(fs_o), .sd(sd), .bck_pin(bck_pin),
      .fs_pin(fs_pin), .edge_rise(er), .drive_rise(dr), .last_frame(last_frame),
      .last_len(last_len), .last_first(last_first), .frames(frames));

   initial forever #12.5 sys_clk = ~sys_clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count = err_count + 1;
         stop_test;
      end
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check({32'h0, x}, {32'h0, e});
   endtask : rdchk

   // Frame as the converter should see it; left overrides right where they meet.
   function automatic logic [63:0] exp_frame(input aocsf_sample_s p, input logic [8:0] lp,
         input logic [8:0] rp, input logic [3:0] st, input logic lsb, input int len);
      logic [63:0] f;
      int k;
      f = '0;
      for (int i = 0; i < len && i < 64; i++) begin
         k = i - int'(rp);
         if (k >= 0 && k < 16 - st) f[i] = lsb ? p.right[st + k] : p.right[15 - k];
         k = i - int'(lp);
         if (k >= 0 && k < 16 - st) f[i] = lsb ? p.left[st + k] : p.left[15 - k];
      end
      return f;
   endfunction : exp_frame

   initial begin
      logic o;
      int n, len;
      logic m, tx, lsb, pl;
      logic [8:0] fl, lp, rp;
      logic [3:0] st;
      logic [7:0] bd;
      logic [63:0] ef;
      o = 1'b0;
      n = 0;
      rstn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      sample_valid <= 1'b1;
      for (int a = 0; a < 28; a += 4) if (a != 16) rdchk(8'(a), 32'h0);
      wr(8'h14, 32'hffffffff);
      rdchk(8'h14, 32'h0);
      wr(`AOCSF_ADDR_POS, 32'hffffffff);
      rdchk(`AOCSF_ADDR_POS, 32'hf1ff01ff);
      wr(`AOCSF_ADDR_STEP, 32'h05555555);
      rdchk(`AOCSF_ADDR_STEP, 32'h05555555);
      $display("test regs done");
      repeat (1600) begin
         @(negedge sys_clk);
         n = n + int'(osc && !o);
         o = osc;
      end
      check(64'(n >= 99 && n <= 101), 64'h1);
      $display("test clock done");
      for (int s = 0; s < 5; s++) begin
         m = (s != 2) && (s != 3);
         tx = (s != 4);
         lsb = s[1];
         pl = s[0];
         fl = (s == 0) ? 9'd63 : 9'd47;
         lp = (s == 0) ? 9'd0 : 9'($unsigned($random(seed)) % 40);
         rp = (s == 0) ? 9'd32 : (s == 3) ? lp : 9'($unsigned($random(seed)) % 40);
         st = (s == 0) ? 4'h0 : (s == 2) ? 4'hf : 4'($random(seed));
         bd = (s == 1) ? 8'h01 : 8'h00;
         do @(posedge sys_clk); while (sample_ready !== 1'b1);
         pair <= aocsf_sample_s'($random(seed));
         er <= s[0];
         dr <= s[0];
         wr(`AOCSF_ADDR_CTRL, {26'h0, 1'b0, lsb, pl, s[0], s[0], m});
         wr(`AOCSF_ADDR_DIV, {7'h0, fl, 8'h00, bd});
         wr(`AOCSF_ADDR_POS, {st, 3'h0, rp, 7'h0, lp});
         wr(`AOCSF_ADDR_CTRL, {26'h0, tx, lsb, pl, s[0], s[0], m});
         n = frames;
         while (frames < n + 4) @(posedge sys_clk);
         len = m ? int'(fl) + 1 : 40;
         check({62'h0, bck_o.en, fs_o.en}, {62'h0, m, m});
         check(64'(last_len), 64'(len));
         check(64'(last_first), (m && pl) ? 64'h1 : 64'((len + 1) / 2));
         ef = tx ? exp_frame(pair, lp, rp, st, lsb, len) : 64'h0;
         check(last_frame, ef);
         $display("test frame %0d done", s);
      end
      rstn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 16; a += 4) rdchk(8'(a), 32'h0);
      $display("test reset done");
      stop_test;
   end
endmodule : test_audio_out_clock_and_serial_framer
